// File: tb.sv
// Self-checking bench for the command front end
`timescale 1ns/1ps
`include "tsc_map.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
    $display("mismatch t=%0t got %h exp %h", $time, (g), (e)); end end
module tb;
    // Inputs driven by the bench
    reg        clock_i, nrst_i, wr_i, rd_i, nw1_fail_i, nw2_fail_i;
    reg        ref_fail_i;
    reg  [4:0] addr_i;
    reg  [7:0] wdata_i, slot_data_i;
    // Outputs of the design
    wire [7:0] rdata_o, conn_islot_o, conn_oslot_o, conn_msg_o, spec_val_o;
    wire [3:0] conn_op_o, conn_qual_o, conn_src_o, conn_dst_o, rate_src_o;
    wire [3:0] pll_ref_src_o, rate_dst_o, frame_width_o;
    wire [2:0] conn_isub_o, conn_osub_o, pll_ref_freq_o, pcm_clk_rate_o;
    wire [2:0] shift_amt_o, clk_out_freq_o;
    wire [1:0] rate_val_o, shift_tgt_o;
    wire [10:0] frame_offset_o;
    wire       conn_go_o, dump_en_o, pcm_clk_en_o, pcm_clk_out_o;
    wire       phase_align_o, rate_go_o, rate_in_o, rate_out_o, shift_go_o;
    wire       shift_after_o, shift_edge_o, spec_go_o, ext_freq_16_o;
    wire       fallback_en_o, frame_edge_o, ready_o, slot_arrived_o;
    wire       slot_rd_in_o;
    wire [11:0] slot_rd_addr_o;
    // Bookkeeping
    int        n_mismatch, n_compared, i;
    reg  [4:0] regs [0:9] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05,
                              5'h06, 5'h07, 5'h08, 5'h0a};
    reg  [3:0] refq [0:4] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h6};
    reg  [3:0] q;

    tsc_cmd_regs i_dut (.*);

    // Free-running core clock, 4 ns period
    initial begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end

    // One register write; returns just after the edge that took it
    task wr(input [4:0] a, input [7:0] v);
        @(posedge clock_i);
        addr_i  <= a;
        wdata_i <= v;
        wr_i    <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
        #1;
    endtask

    // One register read compared against an expected byte
    task chk_rd(input [4:0] a, input [7:0] e);
        @(posedge clock_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1;
        `CHK(rdata_o, e)
    endtask

    // Bounded wait for a status level; still low at the end is a mismatch
    task wait_hi(input int sel);
        for (int k = 0; k < 20; k++) begin
            if ((sel ? slot_arrived_o : ready_o) === 1'b1) break;
            @(posedge clock_i);
            #1;
        end
        `CHK((sel ? slot_arrived_o : ready_o), 1'b1)
    endtask

    task print_verdict;
        if (n_mismatch == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Cuts a hang short well beyond the expected run length
    initial begin
        #80000;
        n_mismatch++;
        print_verdict;
    end

    initial begin
        {nrst_i, wr_i, rd_i, nw1_fail_i, nw2_fail_i, ref_fail_i} = 6'h00;
        addr_i = 5'h00;
        wdata_i = 8'h00;
        slot_data_i = 8'h00;
        repeat (2) @(posedge clock_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        #1;
        `CHK(ready_o, 1'b1)
        `CHK(frame_width_o, 4'h1)
        for (i = 0; i < 10; i++) chk_rd(regs[i], 8'h00);
        chk_rd(`TSC_A_STAT, 8'h01);
        // Operands, including widest slot and both subchannel fields
        wr(`TSC_A_SRC, 8'h0f);
        wr(`TSC_A_ISLOT, 8'hff);
        wr(`TSC_A_DST, 8'h03);
        wr(`TSC_A_OSLOT, 8'h1f);
        wr(`TSC_A_SUBCH, 8'h57);
        wr(`TSC_A_MSG, 8'ha5);
        chk_rd(`TSC_A_SUBCH, 8'h57);
        chk_rd(`TSC_A_ISLOT, 8'hff);
        // Every connection opcode, issued or quiet
        for (i = 0; i < 16; i++) begin
            q = i[3:0] + 4'h1;
            wr(`TSC_A_CONNECTION_COMMAND, {q, i[3:0]});
            if (i >= 1 && i <= 9) begin
                `CHK({conn_go_o, ready_o}, 2'b10)
                `CHK({conn_op_o, conn_qual_o}, {i[3:0], q})
                `CHK({conn_src_o, conn_islot_o}, 12'hfff)
                `CHK({conn_dst_o, conn_oslot_o}, 12'h31f)
                `CHK({conn_isub_o, conn_osub_o}, 6'h3d)
                `CHK(conn_msg_o, 8'ha5)
                wait_hi(0);
            end else begin
                `CHK(conn_go_o, 1'b0)
            end
        end
        `CHK(dump_en_o, 1'b1)
        // Command while busy is dropped; operands snapshot at issue
        wr(`TSC_A_CONNECTION_COMMAND, 8'h11);
        wr(`TSC_A_SRC, 8'h02);
        wr(`TSC_A_CONNECTION_COMMAND, 8'h12);
        `CHK({conn_go_o, conn_src_o}, 5'h0f)
        wait_hi(0);
        chk_rd(`TSC_A_CONNECTION_COMMAND, 8'h11);
        // PLL reference, every source code, then an unused code
        for (i = 0; i < 5; i++) begin
            wr(`TSC_A_GV1, 8'h03 + i[7:0]);
            wr(`TSC_A_CFG1, {refq[i], 4'h2});
            `CHK(pll_ref_src_o, refq[i])
            `CHK(pll_ref_freq_o, 3'h3 + i[2:0])
        end
        wr(`TSC_A_CFG1, 8'h32);
        `CHK(pll_ref_src_o, 4'h6)
        // PCM clock rates and direction, then a refused code
        for (i = 1; i < 5; i++) begin
            wr(`TSC_A_CFG1, {i[0], i[2:0], 4'h6});
            `CHK(pcm_clk_rate_o, i[2:0])
            `CHK({pcm_clk_en_o, pcm_clk_out_o}, {1'b1, i[0]})
        end
        wr(`TSC_A_CFG1, 8'h56);
        `CHK(pcm_clk_rate_o, 3'h4)
        wr(`TSC_A_CFG1, 8'h8a);
        `CHK(phase_align_o, 1'b1)
        wr(`TSC_A_CFG1, 8'hfb);
        `CHK({rate_go_o, rate_val_o}, 3'h7)
        `CHK({rate_in_o, rate_out_o}, 2'b11)
        `CHK({rate_src_o, rate_dst_o}, 8'h23)
        wr(`TSC_A_GV1, 8'h1b);
        wr(`TSC_A_CFG1, 8'h2f);
        `CHK({shift_go_o, shift_tgt_o, shift_after_o}, 4'hd)
        `CHK({shift_amt_o, shift_edge_o}, 4'hb)
        wr(`TSC_A_GV1, 8'h3c);
        wr(`TSC_A_CFG1, 8'hf3);
        `CHK(spec_go_o, 1'b0)
        wr(`TSC_A_CFG1, 8'hf4);
        `CHK({spec_go_o, spec_val_o}, 9'h13c)
        wr(`TSC_A_CFG1, 8'h74);
        `CHK(spec_go_o, 1'b0)
        // Slot reads from both sides; arrival flag cleared by status read
        @(posedge clock_i);
        slot_data_i <= 8'h96;
        wr(`TSC_A_CFG1, 8'h0d);
        `CHK({slot_rd_in_o, slot_rd_addr_o}, 13'h12ff)
        wait_hi(1);
        chk_rd(`TSC_A_SLOTV, 8'h96);
        chk_rd(`TSC_A_STAT, 8'h21);
        @(posedge clock_i);
        slot_data_i <= 8'h69;
        wr(`TSC_A_CFG1, 8'h1d);
        `CHK({slot_rd_in_o, slot_rd_addr_o}, 13'h031f)
        wait_hi(1);
        chk_rd(`TSC_A_SLOTV, 8'h69);
        chk_rd(`TSC_A_STAT, 8'h21);
        chk_rd(`TSC_A_STAT, 8'h01);
        // External frequency with fallback, clock losses and their return
        wr(`TSC_A_CFG2, 8'h31);
        `CHK({ext_freq_16_o, fallback_en_o}, 2'b11)
        @(posedge clock_i);
        {ref_fail_i, nw2_fail_i, nw1_fail_i} <= 3'b011;
        repeat (4) @(posedge clock_i);
        chk_rd(`TSC_A_ERR1, 8'h03);
        chk_rd(`TSC_A_ERR2, 8'h40);
        @(posedge clock_i);
        {ref_fail_i, nw2_fail_i, nw1_fail_i} <= 3'b100;
        repeat (4) @(posedge clock_i);
        chk_rd(`TSC_A_ERR1, 8'h00);
        chk_rd(`TSC_A_ERR2, 8'h40);
        @(posedge clock_i);
        ref_fail_i <= 1'b0;
        repeat (4) @(posedge clock_i);
        chk_rd(`TSC_A_ERR1, 8'h00);
        chk_rd(`TSC_A_ERR2, 8'h00);
        wr(`TSC_A_CFG2, 8'h01);
        `CHK({ext_freq_16_o, fallback_en_o}, 2'b00)
        // Frame and clock signal outputs from both general values
        wr(`TSC_A_GV1, 8'hab);
        wr(`TSC_A_GV2, 8'h53);
        wr(`TSC_A_CFG2, 8'h06);
        `CHK(frame_offset_o, 11'h4ea)
        `CHK({frame_width_o, frame_edge_o}, 5'h07)
        wr(`TSC_A_GV1, 8'h06);
        wr(`TSC_A_CFG2, 8'h07);
        `CHK(clk_out_freq_o, 3'h6)
        print_verdict;
    end
endmodule // tb

// File: tsc_cmd_regs.v
// Command register file and command decoder of the time-slot switch
`timescale 1ns/1ps
`include "tsc_map.vh"
// How it works
// - Eight-bit slot address, stored and passed on whole whatever the rate
// - Subchannel register holds two three-bit fields
// - PLL reference frequency from general value bits
// - Bit shift fields decoded from general value
// - Frame pulse offset built from both values
// - Frame pulse width is field plus one
// - Clock output frequency from general value bits
// - Opcode low nibble, qualifier high; zero nop
// - Constant-delay connect with subchannel width qualifier
// - Minimum-delay connect, send and stop message
// - Disconnect and broadcast-branch disconnect use operands
// - Multipoint, disconnect all, bidirectional, memory dump
// - PLL reference source from qualifier code
// - PCM clocks enabled with rate and direction
// - Line bit rate to input or output line
// - Read slot from input or output side
// - Bit shift applied to chosen line group
// - External frequency and fallback enable
// - Failure flags set on loss, cleared on return, while fallback is enabled
// - Read slot result stored, arrival flag raised
// - Ready flag tells when connect command allowed
module tsc_cmd_regs (
    // Clock and reset
    input  wire        clock_i,
    input  wire        nrst_i,
    // Processor register port
    input  wire [4:0]  addr_i,
    input  wire        wr_i,
    input  wire        rd_i,
    input  wire [7:0]  wdata_i,
    output reg  [7:0]  rdata_o,
    // Datapath: slot content answer and clock monitors (async pins)
    input  wire [7:0]  slot_data_i,
    input  wire        nw1_fail_i,
    input  wire        nw2_fail_i,
    input  wire        ref_fail_i,
    // Connection command issued to the switching core
    output reg         conn_go_o,
    output reg  [3:0]  conn_op_o,
    output reg  [3:0]  conn_qual_o,
    output reg  [3:0]  conn_src_o,
    output reg  [7:0]  conn_islot_o,
    output reg  [3:0]  conn_dst_o,
    output reg  [7:0]  conn_oslot_o,
    output reg  [2:0]  conn_isub_o,
    output reg  [2:0]  conn_osub_o,
    output reg  [7:0]  conn_msg_o,
    output reg         dump_en_o,
    // Decoded configuration state
    output reg  [3:0]  pll_ref_src_o,
    output reg  [2:0]  pll_ref_freq_o,
    output reg         pcm_clk_en_o,
    output reg  [2:0]  pcm_clk_rate_o,
    output reg         pcm_clk_out_o,
    output reg         phase_align_o,
    output reg         rate_go_o,
    output reg  [1:0]  rate_val_o,
    output reg         rate_in_o,
    output reg         rate_out_o,
    output reg  [3:0]  rate_src_o,
    output reg  [3:0]  rate_dst_o,
    output reg         shift_go_o,
    output reg  [1:0]  shift_tgt_o,
    output reg         shift_after_o,
    output reg  [2:0]  shift_amt_o,
    output reg         shift_edge_o,
    output reg         spec_go_o,
    output reg  [7:0]  spec_val_o,
    output reg         ext_freq_16_o,
    output reg         fallback_en_o,
    output reg  [10:0] frame_offset_o,
    output reg  [3:0]  frame_width_o,
    output reg         frame_edge_o,
    output reg  [2:0]  clk_out_freq_o,
    // Status
    output reg         ready_o,
    output reg         slot_arrived_o,
    // Slot read request to the core: side and port/slot address
    output reg         slot_rd_in_o,
    output reg  [11:0] slot_rd_addr_o
);

    // Operand and command registers
    reg  [7:0] src_q, islot_q, dst_q, oslot_q, gv1_q, gv2_q;
    reg  [7:0] connection_command_q, sub_q, cfg1_q, cfg2_q, msg_q;
    reg  [7:0] slotv_q;            // Time-slot value readback
    reg  [3:0] busy_q;             // Connection memory update counter
    reg  [3:0] rdcnt_q;            // Read-slot latency counter
    reg  [2:0] sync1_q, sync2_q;   // Failure pin synchronisers
    reg        rst_m_q, rst_q;     // Reset release pair
    wire       wr_cc, wr_c1, wr_c2;
    wire [3:0] q1;
    wire [3:0] c1op;

    // Reset release: async assert, two-flop release
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_m_q <= 1'b0;
            rst_q   <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_q   <= rst_m_q;
        end
    end

    // Command writes; a write while busy is still taken for config ones
    assign wr_cc = wr_i && (addr_i == `TSC_A_CONNECTION_COMMAND);
    assign wr_c1 = wr_i && (addr_i == `TSC_A_CFG1);
    assign wr_c2 = wr_i && (addr_i == `TSC_A_CFG2);
    assign q1    = wdata_i[7:4];
    assign c1op  = wdata_i[3:0];

    // True when the qualifier code names a supported PLL reference
    function ref_ok;
        input [3:0] q;
        begin
            ref_ok = (q == `TSC_REF_OSC) || (q == `TSC_REF_FS) ||
                     (q == `TSC_REF_DCLK) || (q == `TSC_REF_NW1) ||
                     (q == `TSC_REF_NW2);
        end
    endfunction

    // Operand register file; subchannel bits masked, command held while not ready
    always @(posedge clock_i or negedge rst_q) begin
        if (!rst_q) begin
            src_q   <= `TSC_RST8;
            islot_q <= `TSC_RST8;
            dst_q   <= `TSC_RST8;
            oslot_q <= `TSC_RST8;
            gv1_q   <= `TSC_RST8;
            gv2_q   <= `TSC_RST8;
            connection_command_q  <= `TSC_RST8;
            sub_q   <= `TSC_RST8;
            cfg1_q  <= `TSC_RST8;
            cfg2_q  <= `TSC_RST8;
            msg_q   <= `TSC_RST8;
        end else if (wr_i) begin
            // Address decode by if chain
            if (addr_i == `TSC_A_SRC)
                src_q <= wdata_i;     // Upper nibble left to software
            else if (addr_i == `TSC_A_ISLOT)
                islot_q <= wdata_i;   // Full 8-bit slot
            else if (addr_i == `TSC_A_DST)
                dst_q <= wdata_i;
            else if (addr_i == `TSC_A_OSLOT)
                oslot_q <= wdata_i;
            else if (addr_i == `TSC_A_GV1)
                gv1_q <= wdata_i;
            else if (addr_i == `TSC_A_GV2)
                gv2_q <= wdata_i;
            else if (addr_i == `TSC_A_CONNECTION_COMMAND && ready_o)
                connection_command_q <= wdata_i;    // Ignored while not ready
            else if (addr_i == `TSC_A_SUBCH)
                sub_q <= {1'b0, wdata_i[6:4], 1'b0, wdata_i[2:0]};
            else if (addr_i == `TSC_A_CFG1)
                cfg1_q <= wdata_i;
            else if (addr_i == `TSC_A_CFG2)
                cfg2_q <= wdata_i;
            else if (addr_i == `TSC_A_MSG)
                msg_q <= wdata_i;
        end
    end

    // Connection command launch and busy timing
    always @(posedge clock_i or negedge rst_q) begin
        if (!rst_q) begin
            conn_go_o    <= 1'b0;
            conn_op_o    <= `TSC_CC_NOP;
            conn_qual_o  <= 4'h0;
            conn_src_o   <= 4'h0;
            conn_islot_o <= `TSC_RST8;
            conn_dst_o   <= 4'h0;
            conn_oslot_o <= `TSC_RST8;
            conn_isub_o  <= 3'h0;
            conn_osub_o  <= 3'h0;
            conn_msg_o   <= `TSC_RST8;
            dump_en_o    <= 1'b0;
            busy_q       <= `TSC_CNT_ZERO;
            ready_o      <= 1'b1;
        end else begin
            conn_go_o <= 1'b0;
            if (wr_cc && ready_o && (c1op != `TSC_CC_NOP)) begin
                // Snapshot operands at the write
                if (c1op == `TSC_CC_DUMP) begin
                    dump_en_o <= wdata_i[4];
                end else if (c1op <= `TSC_CC_BIDIR) begin
                    // Opcodes 1..9 reach the core
                    conn_go_o    <= 1'b1;
                    conn_op_o    <= c1op;
                    conn_qual_o  <= q1;
                    conn_src_o   <= src_q[3:0];
                    conn_islot_o <= islot_q;
                    conn_dst_o   <= dst_q[3:0];
                    conn_oslot_o <= oslot_q;
                    conn_isub_o  <= sub_q[2:0];
                    conn_osub_o  <= sub_q[6:4];
                    conn_msg_o   <= msg_q;
                    busy_q       <= `TSC_BUSY_CYC;
                    ready_o      <= 1'b0;
                end
            end else if (busy_q != `TSC_CNT_ZERO) begin
                busy_q <= busy_q - `TSC_CNT_ONE;
                // Ready returns as the update ends
                if (busy_q == `TSC_CNT_ONE)
                    ready_o <= 1'b1;
            end
        end
    end

    // Configuration command one decoder
    always @(posedge clock_i or negedge rst_q) begin
        if (!rst_q) begin
            pll_ref_src_o  <= `TSC_REF_OSC;
            pll_ref_freq_o <= 3'h0;
            pcm_clk_en_o   <= 1'b0;
            pcm_clk_rate_o <= 3'h0;
            pcm_clk_out_o  <= 1'b0;
            phase_align_o  <= 1'b0;
            rate_go_o      <= 1'b0;
            rate_val_o     <= 2'h0;
            rate_in_o      <= 1'b0;
            rate_out_o     <= 1'b0;
            rate_src_o     <= 4'h0;
            rate_dst_o     <= 4'h0;
            shift_go_o     <= 1'b0;
            shift_tgt_o    <= 2'h0;
            shift_after_o  <= 1'b0;
            shift_amt_o    <= 3'h0;
            shift_edge_o   <= 1'b0;
            spec_go_o      <= 1'b0;
            spec_val_o     <= `TSC_RST8;
            rdcnt_q        <= `TSC_CNT_ZERO;
            slot_rd_in_o   <= 1'b0;
            slot_rd_addr_o <= 12'h000;
        end else begin
            rate_go_o  <= 1'b0;
            shift_go_o <= 1'b0;
            spec_go_o  <= 1'b0;
            if (rdcnt_q != `TSC_CNT_ZERO)
                rdcnt_q <= rdcnt_q - `TSC_CNT_ONE;
            if (wr_c1) begin
                case (c1op)
                `TSC_C1_PLLREF: begin
                    if (ref_ok(q1)) begin
                        pll_ref_src_o  <= q1;
                        pll_ref_freq_o <= gv1_q[2:0];
                    end
                end
                `TSC_C1_SPSTART, `TSC_C1_SPWRITE: begin
                    // Only the write code with the key qualifier is acted on; start is ignored
                    if (q1 == `TSC_SP_KEY && c1op == `TSC_C1_SPWRITE) begin
                        spec_go_o  <= 1'b1;
                        spec_val_o <= gv1_q;
                    end
                end
                `TSC_C1_PCMCLK: begin
                    if (q1[2:0] >= `TSC_PCM_MIN && q1[2:0] <= `TSC_PCM_MAX) begin
                        pcm_clk_en_o   <= 1'b1;
                        pcm_clk_rate_o <= q1[2:0];
                        pcm_clk_out_o  <= q1[3];
                    end
                end
                `TSC_C1_ALIGN: begin
                    phase_align_o <= q1[3];
                end
                `TSC_C1_RATE: begin
                    rate_go_o  <= 1'b1;
                    rate_val_o <= q1[1:0];
                    rate_in_o  <= q1[2];
                    rate_out_o <= q1[3];
                    rate_src_o <= src_q[3:0];
                    rate_dst_o <= dst_q[3:0];
                end
                `TSC_C1_RDSLOT: begin
                    // Input side takes the source operands
                    slot_rd_in_o   <= ~q1[0];
                    slot_rd_addr_o <= q1[0] ? {dst_q[3:0], oslot_q}
                                            : {src_q[3:0], islot_q};
                    rdcnt_q        <= `TSC_SLOT_CYC;
                end
                `TSC_C1_SHIFT: begin
                    shift_go_o    <= 1'b1;
                    shift_tgt_o   <= q1[1:0];
                    shift_after_o <= gv1_q[4];
                    shift_amt_o   <= gv1_q[3:1];
                    shift_edge_o  <= gv1_q[0];
                end
                default: begin
                    // Unused codes do nothing
                end
                endcase
            end
        end
    end

    // Read-slot result capture and arrival flag
    always @(posedge clock_i or negedge rst_q) begin
        if (!rst_q) begin
            slotv_q        <= `TSC_RST8;
            slot_arrived_o <= 1'b0;
        end else if (rdcnt_q == `TSC_CNT_ONE) begin
            slotv_q        <= slot_data_i;
            slot_arrived_o <= 1'b1;                    // Set beats read clear
        end else if (rd_i && addr_i == `TSC_A_STAT) begin
            slot_arrived_o <= 1'b0;                    // Cleared by status read
        end
    end

    // Configuration two and frame/clock output fields
    always @(posedge clock_i or negedge rst_q) begin
        if (!rst_q) begin
            ext_freq_16_o  <= 1'b0;
            fallback_en_o  <= 1'b0;
            frame_offset_o <= 11'h000;
            frame_width_o  <= 4'h1;
            frame_edge_o   <= 1'b0;
            clk_out_freq_o <= 3'h0;
        end else begin
            if (wr_c2 && c1op == `TSC_C2_EXTFREQ) begin
                ext_freq_16_o <= q1[0];
                fallback_en_o <= q1[1];
            end
            // Live decode of the general values
            frame_offset_o <= {gv2_q[4:0], gv1_q[7:2]};
            frame_width_o  <= {1'b0, gv2_q[7:5]} + `TSC_CNT_ONE;
            frame_edge_o   <= gv1_q[1];
            clk_out_freq_o <= gv1_q[2:0];
        end
    end

    // Failure pins: two-flop synchronisers, then flag logic
    always @(posedge clock_i or negedge rst_q) begin
        if (!rst_q) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
        end else begin
            sync1_q <= {ref_fail_i, nw2_fail_i, nw1_fail_i};
            sync2_q <= sync1_q;
        end
    end

    // Flags follow the clocks only while fallback is on
    wire [2:0] fail_w = fallback_en_o ? sync2_q : 3'h0;
    wire       pll_w  = |fail_w;

    // Register readback
    always @(posedge clock_i or negedge rst_q) begin
        if (!rst_q) begin
            rdata_o <= `TSC_RST8;
        end else if (addr_i == `TSC_A_SRC)     rdata_o <= src_q;
        else if (addr_i == `TSC_A_ISLOT)       rdata_o <= islot_q;
        else if (addr_i == `TSC_A_DST)         rdata_o <= dst_q;
        else if (addr_i == `TSC_A_OSLOT)       rdata_o <= oslot_q;
        else if (addr_i == `TSC_A_GV1)         rdata_o <= gv1_q;
        else if (addr_i == `TSC_A_GV2)         rdata_o <= gv2_q;
        else if (addr_i == `TSC_A_CONNECTION_COMMAND)        rdata_o <= connection_command_q;
        else if (addr_i == `TSC_A_SUBCH)       rdata_o <= sub_q;
        else if (addr_i == `TSC_A_CFG1)        rdata_o <= cfg1_q;
        else if (addr_i == `TSC_A_CFG2)        rdata_o <= cfg2_q;
        else if (addr_i == `TSC_A_MSG)         rdata_o <= msg_q;
        else if (addr_i == `TSC_A_STAT)
            rdata_o <= {2'b00, slot_arrived_o, 4'h0, ready_o};
        else if (addr_i == `TSC_A_ERR1)
            rdata_o <= {6'h00, fail_w[1:0]};
        else if (addr_i == `TSC_A_ERR2)
            rdata_o <= {1'b0, pll_w, 6'h00};
        else if (addr_i == `TSC_A_SLOTV)       rdata_o <= slotv_q;
        else                                   rdata_o <= `TSC_RST8;
    end

endmodule // tsc_cmd_regs

// File: tsc_cmd_regs_assertions.sv
// Port-level checker for the command front end, bound to its top module
`timescale 1ns/1ps
`include "tsc_map.vh"
module tsc_cmd_regs_assertions (
    // Clock and reset
    input wire        clock_i,
    input wire        nrst_i,
    // Register port
    input wire [4:0]  addr_i,
    input wire        wr_i,
    input wire [7:0]  wdata_i,
    // Watched outputs
    input wire        conn_go_o,
    input wire [3:0]  conn_op_o,
    input wire [3:0]  conn_qual_o,
    input wire        ready_o,
    input wire        rate_go_o,
    input wire [1:0]  rate_val_o,
    input wire        rate_in_o,
    input wire        rate_out_o,
    input wire        shift_go_o,
    input wire [1:0]  shift_tgt_o,
    input wire        pcm_clk_en_o,
    input wire        ext_freq_16_o,
    input wire        fallback_en_o,
    input wire [3:0]  frame_width_o,
    input wire        slot_arrived_o
);
    // Write data of the previous cycle, so command fields can be compared a cycle later
    reg  [7:0] wd_q;
    // Write strobes per command register
    wire       cc_wr = wr_i && (addr_i == `TSC_A_CONNECTION_COMMAND);
    wire       c1_wr = wr_i && (addr_i == `TSC_A_CFG1);
    wire       c2_wr = wr_i && (addr_i == `TSC_A_CFG2);
    wire [3:0] op    = wdata_i[3:0];

    // Capture of write data
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wd_q <= 8'h00;
        end else begin
            wd_q <= wdata_i;
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);

    a_conn_go_issue: assert property (
        cc_wr && ready_o && op >= 4'h1 && op <= 4'h9 |=> conn_go_o &&
        conn_op_o == wd_q[3:0] && conn_qual_o == wd_q[7:4])
        else $error("connection command not issued with its fields");
    a_nop_quiet: assert property (
        cc_wr && (op == 4'h0 || op >= 4'ha) |=> !conn_go_o)
        else $error("nop or unused opcode issued a command");
    a_busy_refuse: assert property (
        cc_wr && !ready_o |=> !conn_go_o)
        else $error("command accepted while not ready");
    a_ready_busy: assert property (
        conn_go_o |-> (!ready_o)[*7] ##[1:2] ready_o)
        else $error("ready not low for the busy span");
    a_rate_fields: assert property (
        c1_wr && op == 4'hb |=> rate_go_o && rate_val_o == wd_q[5:4] &&
        rate_in_o == wd_q[6] && rate_out_o == wd_q[7])
        else $error("bit rate command fields wrong");
    a_shift_fields: assert property (
        c1_wr && op == 4'hf |=> shift_go_o && shift_tgt_o == wd_q[5:4])
        else $error("bit shift command target wrong");
    a_pcm_refuse: assert property (
        c1_wr && op == 4'h6 && (wdata_i[6:4] == 3'h0 || wdata_i[6:4] > 3'h4)
        |=> $stable(pcm_clk_en_o))
        else $error("bad pcm clock code changed state");
    a_slot_arrive: assert property (
        c1_wr && op == 4'hd |-> ##[3:6] slot_arrived_o)
        else $error("slot arrival not flagged in time");
    a_ext_freq: assert property (
        c2_wr && op == 4'h1 |=> ext_freq_16_o == wd_q[4] &&
        fallback_en_o == wd_q[5])
        else $error("external frequency fields wrong");
    a_width_range: assert property (
        frame_width_o >= 4'h1 && frame_width_o <= 4'h8)
        else $error("frame width out of range");

    // Main scenarios reached
    c_conn: cover property (conn_go_o ##1 !conn_go_o);
    c_rate: cover property (rate_go_o);
    c_slot: cover property ($rose(slot_arrived_o));
endmodule // tsc_cmd_regs_assertions

bind tsc_cmd_regs tsc_cmd_regs_assertions i_chk (
    .clock_i, .nrst_i, .addr_i, .wr_i, .wdata_i, .conn_go_o, .conn_op_o,
    .conn_qual_o, .ready_o, .rate_go_o, .rate_val_o, .rate_in_o,
    .rate_out_o, .shift_go_o, .shift_tgt_o, .pcm_clk_en_o, .ext_freq_16_o,
    .fallback_en_o, .frame_width_o, .slot_arrived_o
);

// File: tsc_map.vh
// Register offsets, codes, timing counts and reset values of the command front end
`ifndef TSC_MAP_VH
`define TSC_MAP_VH
// Register offsets (byte addresses on the 8-bit processor port)
`define TSC_A_SRC       5'h00
`define TSC_A_ISLOT     5'h01
`define TSC_A_DST       5'h02
`define TSC_A_OSLOT     5'h03
`define TSC_A_GV1       5'h04
`define TSC_A_GV2       5'h05
`define TSC_A_CONNECTION_COMMAND      5'h06
`define TSC_A_SUBCH     5'h07
`define TSC_A_CFG1      5'h08
`define TSC_A_CFG2      5'h0a
`define TSC_A_MSG       5'h0c
`define TSC_A_STAT      5'h0e
`define TSC_A_ERR1      5'h10
`define TSC_A_ERR2      5'h11
`define TSC_A_SLOTV     5'h1e
`define TSC_RST8        8'h00
// Connection opcodes
`define TSC_CC_NOP      4'h0
`define TSC_CC_CONST    4'h1
`define TSC_CC_MIN      4'h2
`define TSC_CC_SEND     4'h3
`define TSC_CC_STOP     4'h4
`define TSC_CC_DISC     4'h5
`define TSC_CC_DISCB    4'h6
`define TSC_CC_MULTI    4'h7
`define TSC_CC_DISCALL  4'h8
`define TSC_CC_BIDIR    4'h9
`define TSC_CC_DUMP     4'ha
// Configuration-1 opcodes
`define TSC_C1_PLLREF   4'h2
`define TSC_C1_SPSTART  4'h3
`define TSC_C1_SPWRITE  4'h4
`define TSC_C1_PCMCLK   4'h6
`define TSC_C1_ALIGN    4'ha
`define TSC_C1_RATE     4'hb
`define TSC_C1_RDSLOT   4'hd
`define TSC_C1_SHIFT    4'hf
// Configuration-2 opcodes
`define TSC_C2_EXTFREQ  4'h1
// PLL reference qualifiers
`define TSC_REF_OSC     4'h0
`define TSC_REF_FS      4'h1
`define TSC_REF_DCLK    4'h2
`define TSC_REF_NW1     4'h5
`define TSC_REF_NW2     4'h6
`define TSC_SP_KEY      4'hf
// PCM clock qualifier range
`define TSC_PCM_MIN     3'h1
`define TSC_PCM_MAX     3'h4
// Timing: connection memory update and read-slot latency lengths in cycles
`define TSC_BUSY_CYC    4'h8
`define TSC_SLOT_CYC    4'h4
`define TSC_CNT_ONE     4'h1
`define TSC_CNT_ZERO    4'h0
`endif
